/* hw/dpsh_host.sv */
// host controller driving a four-slice path switch array
`include "dpsh_consts.svh"

module dpsh_host #(
    parameter int SLICES = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pair_mode,
    input wire logic cmd_valid,
    input wire dpsh_pkg::dpsh_cmd_s cmd,
    output logic cmd_ready,
    output logic cmd_error,
    output logic done,
    output logic [4*SLICES-1:0] result,
    output logic shift_spill,
    output dpsh_pkg::dpsh_ctrl_s function_select,
    output logic output_drive_enable_n,
    output logic right_shift_in_n,
    output logic left_shift_in_n,
    input wire logic [4*SLICES-1:0] result_bus_n,
    input wire logic left_shift_out_n,
    input wire logic right_shift_out_n
);
    import dpsh_pkg::*;

    localparam int WAIT = `DPSH_WAIT_CYC;
    localparam int DONE_LAT = WAIT + 1;
    localparam int SW = 4 * SLICES + 2;

    typedef enum logic [1:0] {DPSH_IDLE, DPSH_BUSY, DPSH_DONE} dpsh_state_e;

    dpsh_state_e state_reg;
    dpsh_state_e state_next;
    logic [3:0] wait_reg;
    dpsh_op_e op_reg;
    logic [SW-1:0] pins_sync;
    logic take;
    logic refuse;
    dpsh_ctrl_s want;

    // -----------------------------------------------------------------
    // op to array control word
    // -----------------------------------------------------------------
    function automatic dpsh_ctrl_s dpsh_encode(input dpsh_op_e op);
        dpsh_ctrl_s c;
        c = '{shared: `DPSH_SH_CONST, bit0: `DPSH_B0_HIGH};
        unique case (op)
            DPSH_PASS_D: c = '{shared: `DPSH_SH_LOAD, bit0: `DPSH_B0_LOW};
            DPSH_PASS_K: c = '{shared: `DPSH_SH_LOAD, bit0: `DPSH_B0_HIGH};
            // low slices pass and export sign, high slices replicate it
            DPSH_SEXT_D: c = '{shared: `DPSH_SH_SEXT_D, bit0: `DPSH_B0_BYTE_SPLIT};
            DPSH_SEXT_K: c = '{shared: `DPSH_SH_SEXT_K, bit0: `DPSH_B0_BYTE_SPLIT};
            // high byte driven high (logical zero), low byte low: 00ff logical
            DPSH_MASK_LO: c = '{shared: `DPSH_SH_MASK, bit0: `DPSH_B0_MASK_LO};
            DPSH_ZERO: c = '{shared: `DPSH_SH_CONST, bit0: `DPSH_B0_HIGH};
            DPSH_PLUS1: c = '{shared: `DPSH_SH_CONST, bit0: `DPSH_B0_LSB_ONLY};
            DPSH_MINUS1: c = '{shared: `DPSH_SH_NEG, bit0: `DPSH_B0_HIGH};
            DPSH_MINUS2: c = '{shared: `DPSH_SH_NEG, bit0: `DPSH_B0_LSB_ONLY};
            DPSH_SHL_D: c = '{shared: `DPSH_SH_SHL, bit0: `DPSH_B0_LOW};
            DPSH_SHL_K: c = '{shared: `DPSH_SH_SHL, bit0: `DPSH_B0_HIGH};
            DPSH_SHR_D: c = '{shared: `DPSH_SH_SHR_D, bit0: `DPSH_B0_LOW};
            // only the top slice keeps the sign, the rest shift logically
            DPSH_SAR_D: c = '{shared: `DPSH_SH_SHR_D, bit0: `DPSH_B0_MSB_ONLY};
            DPSH_SHR_K: c = '{shared: `DPSH_SH_SHR_K, bit0: `DPSH_B0_LOW};
            DPSH_SAR_K: c = '{shared: `DPSH_SH_SHR_K, bit0: `DPSH_B0_MSB_ONLY};
            DPSH_COMP_D: c = '{shared: `DPSH_SH_COMP, bit0: `DPSH_B0_LOW};
        endcase
        return c;
    endfunction

    function automatic logic dpsh_pair_ok(input dpsh_ctrl_s c);
        return (c.bit0[0] == c.bit0[1]) && (c.bit0[2] == c.bit0[3]);
    endfunction

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    dpsh_sync #(
        .WIDTH(SW)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in({left_shift_out_n, right_shift_out_n, result_bus_n}),
        .sync_out(pins_sync)
    );

    // -----------------------------------------------------------------
    // sequencing
    // -----------------------------------------------------------------
    assign want = dpsh_encode(cmd.op);
    assign take = (state_reg == DPSH_IDLE) && cmd_valid && !refuse;
    // six-line wiring cannot express a split inside a byte pair
    assign refuse = pair_mode && !dpsh_pair_ok(want);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            DPSH_IDLE: if (take) state_next = DPSH_BUSY;
            DPSH_BUSY: if (wait_reg == 4'h0) state_next = DPSH_DONE;
            DPSH_DONE: state_next = DPSH_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state_reg <= DPSH_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            wait_reg <= 4'h0;
        else if (take)
            wait_reg <= 4'(WAIT - 1);
        else if (wait_reg != 4'h0)
            wait_reg <= wait_reg - 4'h1;
    end

    // -----------------------------------------------------------------
    // array drive: one shared group plus a bit zero per slice
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            function_select <= '{shared: `DPSH_SH_CONST, bit0: `DPSH_B0_HIGH};
            op_reg <= DPSH_ZERO;
            right_shift_in_n <= 1'b1;
            left_shift_in_n <= 1'b1;
        end
        else if (take)
        begin
            function_select <= want;
            op_reg <= cmd.op;
            // fill bit enters the lowest slice on left shift, the highest on right
            right_shift_in_n <= ~cmd.fill;
            left_shift_in_n <= ~cmd.fill;
        end
    end

    // bus only driven while a command is in flight, so others may share it
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            output_drive_enable_n <= 1'b1;
        else
            output_drive_enable_n <= !(take || state_next == DPSH_BUSY);
    end

    // -----------------------------------------------------------------
    // answer
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result <= '0;
            shift_spill <= 1'b0;
        end
        else if (state_reg == DPSH_BUSY && wait_reg == 4'h0)
        begin
            result <= ~pins_sync[4*SLICES-1:0];
            // top slice left output on left shifts, bottom right output otherwise
            shift_spill <= (op_reg == DPSH_SHL_D || op_reg == DPSH_SHL_K) ?
                ~pins_sync[SW-1] : ~pins_sync[SW-2];
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done <= 1'b0;
            cmd_error <= 1'b0;
            cmd_ready <= 1'b0;
        end
        else
        begin
            done <= (state_reg == DPSH_BUSY) && (wait_reg == 4'h0);
            cmd_error <= (state_reg == DPSH_IDLE) && cmd_valid && refuse;
            cmd_ready <= (state_next == DPSH_IDLE) && !take;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_ctrl_held: assert property ((state_reg == DPSH_BUSY) && $past(state_reg == DPSH_BUSY)
        |-> $stable(function_select)) else $error("control changed mid command");
    a_pair_tied: assert property (take && pair_mode ##1 1'b1
        |-> dpsh_pair_ok(function_select)) else $error("pair bit zero split");
    a_shl_fill: assert property (take && cmd.fill
        |=> !right_shift_in_n && !left_shift_in_n) else $error("fill not driven");
    a_shr_fill: assert property (take && !cmd.fill
        |=> left_shift_in_n) else $error("right fill wrong");
    a_sext_d: assert property (take && cmd.op == DPSH_SEXT_D
        |=> function_select.shared == 4'h9 && function_select.bit0 == 4'h3)
        else $error("d sign extend code wrong");
    a_sext_k: assert property (take && cmd.op == DPSH_SEXT_K
        |=> function_select.shared == 4'h8 && function_select.bit0 == 4'h3)
        else $error("k sign extend code wrong");
    a_result_inv: assert property (state_reg == DPSH_BUSY && wait_reg == 4'h0
        |=> result == ~$past(pins_sync[4*SLICES-1:0])) else $error("result not inverted");
    a_plus1_lsb: assert property (take && cmd.op == DPSH_PLUS1
        |=> function_select.bit0 == 4'he) else $error("plus one slice order");
    a_done_time: assert property (take |-> ##DONE_LAT done)
        else $error("answer latency wrong");
    a_bus_float: assert property (state_reg == DPSH_IDLE && !take
        |=> output_drive_enable_n) else $error("bus driven while idle");

    c_sext_done: cover property (take && cmd.op == DPSH_SEXT_D ##[1:20] done);
    c_sar_done: cover property (take && cmd.op == DPSH_SAR_K ##[1:20] done);
    c_refused: cover property (cmd_error);
    c_back_to_back: cover property (done ##[1:3] take);
endmodule

/* hw/dpsh_consts.svh */
// constants for the path switch slice array host controller
`ifndef DPSH_CONSTS_SVH
`define DPSH_CONSTS_SVH

// -----------------------------------------------------------------
// shared instruction lines four to one
// -----------------------------------------------------------------
`define DPSH_SH_MASK 4'h0
`define DPSH_SH_NEG 4'h1
`define DPSH_SH_LOAD 4'h6
`define DPSH_SH_CONST 4'h7
`define DPSH_SH_SEXT_K 4'h8
`define DPSH_SH_SEXT_D 4'h9
`define DPSH_SH_SHL 4'ha
`define DPSH_SH_SHR_D 4'hb
`define DPSH_SH_SHR_K 4'hc
`define DPSH_SH_COMP 4'he

// -----------------------------------------------------------------
// per-slice bit zero patterns, slice four down to slice one
// -----------------------------------------------------------------
`define DPSH_B0_LOW 4'h0
`define DPSH_B0_HIGH 4'hf
`define DPSH_B0_BYTE_SPLIT 4'h3
`define DPSH_B0_MASK_LO 4'hc
`define DPSH_B0_LSB_ONLY 4'he
`define DPSH_B0_MSB_ONLY 4'h8

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define DPSH_CLK_NS 10
`define DPSH_SETTLE_NS 27
`define DPSH_SETTLE_CYC ((`DPSH_SETTLE_NS + `DPSH_CLK_NS - 1) / `DPSH_CLK_NS)
`define DPSH_WAIT_CYC (`DPSH_SETTLE_CYC + 3)

`endif

/* hw/dpsh_pkg.sv */
// types for the path switch slice array host controller
package dpsh_pkg;

    typedef enum logic [3:0] {
        DPSH_PASS_D,
        DPSH_PASS_K,
        DPSH_SEXT_D,
        DPSH_SEXT_K,
        DPSH_MASK_LO,
        DPSH_ZERO,
        DPSH_PLUS1,
        DPSH_MINUS1,
        DPSH_MINUS2,
        DPSH_SHL_D,
        DPSH_SHL_K,
        DPSH_SHR_D,
        DPSH_SAR_D,
        DPSH_SHR_K,
        DPSH_SAR_K,
        DPSH_COMP_D
    } dpsh_op_e;

    typedef struct packed {
        dpsh_op_e op;
        logic fill;
    } dpsh_cmd_s;

    typedef struct packed {
        logic [3:0] shared;
        logic [3:0] bit0;
    } dpsh_ctrl_s;

endpackage

/* hw/dpsh_sync.sv */
// two-stage synchroniser for the array's returning pins
module dpsh_sync #(
    parameter int WIDTH = 18
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // pins idle high, which is logical zero on this active-low array
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

/* bench/dpsh_array.sv */
// behavioural four-slice path switch array facing the host
module dpsh_array (
    input wire dpsh_pkg::dpsh_ctrl_s function_select,
    input wire logic output_drive_enable_n,
    input wire logic right_shift_in_n,
    input wire logic left_shift_in_n,
    input wire logic [15:0] first_operand_bus_n,
    input wire logic [15:0] second_operand_bus_n,
    output logic [15:0] result_bus_n,
    output logic left_shift_out_n,
    output logic right_shift_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    import dpsh_pkg::*;

    logic [15:0] drv;
    logic [15:0] held;
    logic [3:0] lo;
    logic [3:0] ro;

    // ----------------------------------------
    // one slice, electrical pin levels
    // ----------------------------------------
    function automatic logic [5:0] one_slice(input logic [4:0] c, input logic [3:0] d,
        input logic [3:0] k, input logic ri, input logic li);
        logic [3:0] o;
        logic l;
        case (c)
            5'h00, 5'h03, 5'h07, 5'h0b: o = 4'h0;
            5'h01, 5'h05, 5'h09, 5'h0f, 5'h1b: o = 4'hf;
            5'h02: o = 4'h1;
            5'h08: o = 4'h7;
            5'h0e: o = 4'he;
            5'h04, 5'h06, 5'h0c, 5'h13: o = d;
            5'h0a, 5'h0d, 5'h11, 5'h1a: o = k;
            5'h10, 5'h12: o = {4{ri}};
            5'h14: o = {d[2:0], ri};
            5'h15: o = {k[2:0], ri};
            5'h16: o = {li, d[3:1]};
            5'h17: o = {d[3], d[3:1]};
            5'h18: o = {li, k[3:1]};
            5'h19: o = {k[3], k[3:1]};
            5'h1c: o = ~d;
            5'h1d: o = ~k;
            default: o = ~d ^ k; // reserved codes give garbage
        endcase
        case (c)
            5'h10, 5'h12: l = ri;
            5'h11, 5'h15: l = k[3];
            5'h13, 5'h14: l = d[3];
            default: l = ~ri; // unspecified, so never a helpful echo
        endcase
        return {l, o, (c[4:1] == 4'hb) ? d[0] : ((c[4:1] == 4'hc) ? k[0] : ~li)};
    endfunction

    // ----------------------------------------
    // array wiring
    // ----------------------------------------
    always_comb
    begin
        logic ri;
        logic [3:0] li;
        logic [5:0] s;
        ri = 1'b1;
        li = 4'hf;
        s = 6'h00;
        for (int i = 0; i < 4; i++)
        begin
            s = one_slice({function_select.shared, function_select.bit0[i]},
                first_operand_bus_n[4*i+:4], second_operand_bus_n[4*i+:4], 1'b1, 1'b1);
            ro[i] = s[0];
        end
        li = {left_shift_in_n, ro[3:1]};
        ri = right_shift_in_n;
        for (int i = 0; i < 4; i++)
        begin
            s = one_slice({function_select.shared, function_select.bit0[i]},
                first_operand_bus_n[4*i+:4], second_operand_bus_n[4*i+:4], ri, li[i]);
            lo[i] = s[5];
            drv[4*i+:4] = s[4:1];
            ri = s[5];
        end
    end

    // a released bus shows the inverse of its last value, never a kind copy
    always_latch
        if (!output_drive_enable_n)
            held <= drv;
    assign result_bus_n = output_drive_enable_n ? ~held : drv;
    assign left_shift_out_n = lo[3];
    assign right_shift_out_n = ro[0];
endmodule

/* bench/tb.sv */
// self-checking bench for the path switch array host controller
`include "dpsh_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dpsh_pkg::*;

    localparam logic [15:0] DV = 16'h8a53;
    localparam logic [15:0] KV = 16'hbcf1;
    logic clk, resetn, pair_mode, cmd_valid, cmd_ready, cmd_error, done, shift_spill;
    logic oe_n, rsi_n, lsi_n, lso_n, rso_n;
    logic [15:0] result, res_n, d_n, k_n;
    dpsh_cmd_s cmd;
    dpsh_ctrl_s fsel;
    int failures;
    int cmp_count;

    dpsh_host dut (.clk(clk), .resetn(resetn), .pair_mode(pair_mode), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .cmd_error(cmd_error), .done(done), .result(result),
        .shift_spill(shift_spill), .function_select(fsel), .output_drive_enable_n(oe_n),
        .right_shift_in_n(rsi_n), .left_shift_in_n(lsi_n), .result_bus_n(res_n),
        .left_shift_out_n(lso_n), .right_shift_out_n(rso_n));
    dpsh_array far_end (.function_select(fsel), .output_drive_enable_n(oe_n),
        .right_shift_in_n(rsi_n), .left_shift_in_n(lsi_n), .first_operand_bus_n(d_n),
        .second_operand_bus_n(k_n), .result_bus_n(res_n), .left_shift_out_n(lso_n),
        .right_shift_out_n(rso_n));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic give_up(input logic bad);
        if (bad)
        begin
            failures++;
            stop_test();
        end
    endtask

    // outputs are registered, so a read just after the edge sees the pre-edge value
    task automatic run_op(input dpsh_op_e op, input logic f, input logic [15:0] e,
        input logic sp_on, input logic sp);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= '{op: op, fill: f};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (cmd_ready !== 1'b1 && n < 40);
        give_up(cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
            if (done !== 1'b1)
            begin
                check(16'(oe_n), 16'h0);
                if (pair_mode)
                    check(16'({fsel.bit0[0] ^ fsel.bit0[1], fsel.bit0[2] ^ fsel.bit0[3]}), 16'h0);
            end
        end
        while (done !== 1'b1 && n < 40);
        give_up(done !== 1'b1);
        check(16'(n), 16'(`DPSH_WAIT_CYC + 1));
        check(result, e);
        if (sp_on)
            check(16'(shift_spill), 16'(sp));
    endtask

    task automatic t_reset();
        repeat (8) @(posedge clk);
        check(16'({cmd_ready, oe_n}), 16'h1);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        check(16'(cmd_ready), 16'h1);
    endtask

    task automatic t_all_ops();
        logic [15:0] e;
        logic s;
        logic f;
        dpsh_op_e op;
        for (int i = 0; i < 16; i++)
        begin
            op = dpsh_op_e'(i);
            f = i[0];
            s = 1'b0;
            case (op)
                DPSH_PASS_D: e = DV;
                DPSH_PASS_K: e = KV;
                DPSH_SEXT_D: e = {{8{DV[7]}}, DV[7:0]};
                DPSH_SEXT_K: e = {{8{KV[7]}}, KV[7:0]};
                DPSH_MASK_LO: e = 16'h00ff;
                DPSH_ZERO: e = 16'h0000;
                DPSH_PLUS1: e = 16'h0001;
                DPSH_MINUS1: e = 16'hffff;
                DPSH_MINUS2: e = 16'hfffe;
                DPSH_SHL_D: {s, e} = {DV, f};
                DPSH_SHL_K: {s, e} = {KV, f};
                DPSH_SHR_D: {e, s} = {f, DV};
                DPSH_SAR_D: {e, s} = {DV[15], DV};
                DPSH_SHR_K: {e, s} = {f, KV};
                DPSH_SAR_K: {e, s} = {KV[15], KV};
                default: e = ~DV;
            endcase
            run_op(op, f, e, i > 8 && i < 15, s);
        end
    endtask

    // a split bit zero cannot be wired when pairs are tied, so the host refuses it
    task automatic t_pair();
        int hits;
        hits = 0;
        @(posedge clk);
        pair_mode <= 1'b1;
        cmd_valid <= 1'b1;
        cmd <= '{op: DPSH_SAR_D, fill: 1'b0};
        repeat (4)
        begin
            @(posedge clk);
            if (cmd_error === 1'b1)
                hits++;
            check(16'(oe_n), 16'h1);
        end
        cmd_valid <= 1'b0;
        check(16'(hits > 0), 16'h1);
        run_op(DPSH_SHL_K, 1'b1, {KV[14:0], 1'b1}, 1'b1, KV[15]);
        run_op(DPSH_MINUS1, 1'b0, 16'hffff, 1'b0, 1'b0);
        pair_mode <= 1'b0;
    endtask

    initial
    begin
        failures = 0;
        cmp_count = 0;
        resetn = 1'b0;
        pair_mode = 1'b0;
        cmd_valid = 1'b0;
        cmd = '{op: DPSH_ZERO, fill: 1'b0};
        d_n = ~DV;
        k_n = ~KV;
        t_reset();
        t_all_ops();
        t_pair();
        stop_test();
    end
endmodule
